//--- common/osk_defs.svh
/*
 * Constants of the amplitude shaping and update control block: register
 * offsets, control bit positions, reset values and sync clock timing.
 * Assumes it is included by its bare name after the package is compiled.
 */
`ifndef OSK_DEFS_SVH
`define OSK_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_AMP_SCALE    8'h04
`define OFS_RAMP_RATE    8'h08
`define OFS_TUNING       8'h0c
`define OFS_STATUS       8'h10

// ----------------------------------------------------------------------
// Bit positions in the first control word.
// ----------------------------------------------------------------------
`define BIT_LOAD_TIMER   26
`define BIT_KEY_ENABLE   25
`define BIT_KEY_AUTO     24
`define BIT_AUTO_CLEAR   13
`define BIT_CONT_CLEAR   10

// ----------------------------------------------------------------------
// Field layout of the amplitude scale word.
// ----------------------------------------------------------------------
`define ASW_STEP_HI      15
`define ASW_STEP_LO      14
`define ASW_CEIL_HI      13

// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define RST_CONTROL      32'h0000_0000
`define RST_AMP_SCALE    16'h0000
`define RST_RAMP_RATE    8'h00
`define RST_TUNING       32'h0000_0000
`define SYNC_DIV         4
`define SYNC_CNT_LAST    2'h3
`define SCALE_SHIFT      14
`define HTRANS_NONSEQ_BIT 1

`endif

//--- common/osk_pkg.sv
/*
 * Types shared by the amplitude shaping and update control block.
 * Assumes nothing of its surroundings.
 */
package osk_pkg;

	// One set of control registers; used for both the write buffers and the active copies.
	typedef struct packed {
		logic [31:0] control;     // First control word.
		logic [15:0] amp_scale;   // Amplitude scale word.
		logic [7:0]  ramp_rate;   // Ramp rate word.
		logic [31:0] tuning;      // Phase accumulator step.
	} regs_t;

	// Captured AHB-Lite address phase.
	typedef struct packed {
		logic       valid;        // A transfer is in its data phase.
		logic       write;        // The transfer is a write.
		logic [7:0] addr;         // Low byte of the address.
	} ahb_phase_t;

	// Progress of an update request through the sync clock.
	typedef enum logic [0:0] {
		UPD_IDLE,
		UPD_ARMED
	} upd_state_t;

endpackage : osk_pkg

//--- verif/amplitude_shaping_update_ctrl_sva.sv
/*
 * Port checker for the shaping block.
 * Assumes it is bound to the top module and one clock domain.
 */
module asu_checker #(
	parameter int SAMPLE_W = 14,
	parameter int SCALE_W  = 14
) (
	// Clock and reset.
	input wire logic                clk,
	input wire logic                reset_n,
	// Bus.
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic [31:0]         hrdata,
	input wire logic                hreadyout,
	input wire logic                hresp,
	// Pins and datapath.
	input wire logic                io_update,
	input wire logic                keying_input_pin,
	input wire logic [SAMPLE_W-1:0] core_sample,
	input wire logic [31:0]         phase_acc,
	input wire logic [SAMPLE_W-1:0] scaled_sample,
	input wire logic [SCALE_W-1:0]  scale_factor
);
	// -----------------------------------------------------------------
	// Helper logic.
	// -----------------------------------------------------------------
	logic [SAMPLE_W+SCALE_W-1:0] prod;         // Full product of sample and factor.
	logic [3:0]                  upd_age;      // Cycles since the update pin was high.
	logic [3:0]                  next_upd_age; // Next age, saturating.
	assign prod = core_sample * scale_factor;
	// Ages the update pin so slew is only judged far from a copy.
	always_comb begin
		next_upd_age = (upd_age == 4'hf) ? upd_age : upd_age + 4'h1;
		if (io_update) begin
			next_upd_age = 4'h0;
		end
	end
	// Registers the age.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upd_age <= 4'h0;
		end else begin
			upd_age <= next_upd_age;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// A read request taken at one address.
	sequence s_rd(logic [7:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	// Factor held steady over two edges, sample over the second one.
	sequence s_steady;
		$stable(scale_factor) ##1 ($stable(scale_factor) && $stable(core_sample));
	endsequence
	// -----------------------------------------------------------------
	// Assertions.
	// -----------------------------------------------------------------
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_reset_zero: assert property (disable iff (1'b0) !reset_n |->
		phase_acc == 32'h0 && scale_factor == '0 && scaled_sample == '0)
		else $error("outputs not cleared in reset");
	a_rate_width: assert property (s_rd(8'h08) |=> hrdata[31:8] == 24'h0)
		else $error("ramp rate read wider than eight bits");
	a_amp_width: assert property (s_rd(8'h04) |=> hrdata[31:16] == 16'h0)
		else $error("scale word read wider than sixteen bits");
	a_unmapped_zero: assert property (s_rd(8'h20) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_view: assert property (s_rd(8'h10) |=>
		hrdata == {17'h0, $past(keying_input_pin), $past(scale_factor)})
		else $error("status read wrong");
	a_scale_product: assert property (s_steady |->
		scaled_sample == prod[SAMPLE_W+SCALE_W-1:SCALE_W] || scaled_sample == core_sample)
		else $error("scaled sample not product over full scale");
	a_ramp_slew: assert property (upd_age == 4'hf |-> ((scale_factor >= $past(scale_factor)) ?
		(scale_factor - $past(scale_factor) <= 8) : ($past(scale_factor) - scale_factor <= 8)))
		else $error("scale factor jumped by more than eight");
endmodule : asu_checker

bind amplitude_shaping_update_ctrl asu_checker #(.SAMPLE_W(SAMPLE_W), .SCALE_W(SCALE_W))
	asu_checker_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .io_update(io_update),
	.keying_input_pin(keying_input_pin), .core_sample(core_sample),
	.phase_acc(phase_acc), .scaled_sample(scaled_sample), .scale_factor(scale_factor));

//--- verif/amplitude_shaping_update_ctrl_tb_top.sv
/*
 * Register-level bench of the shaping block.
 * Assumes the defines header and the host model are compiled first.
 */
`include "osk_defs.svh"
module amplitude_shaping_update_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import osk_pkg::*;
	logic        clk, reset_n, hwrite, hreadyout, hresp, io_update, keying_input_pin;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, phase_acc, a0, rd;
	logic [13:0] core_sample, scaled_sample, scale_factor, prev;
	int          num_errors, checks_done, n, cyc;
	localparam logic [13:0] FAC [3] = '{14'h2000, 14'h3fff, 14'h0000};
	localparam logic [13:0] OUT [3] = '{14'h1800, 14'h2fff, 14'h0000};
	amplitude_shaping_update_ctrl amplitude_shaping_update_ctrl_i (.clk(clk),
		.reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .io_update(io_update),
		.keying_input_pin(keying_input_pin), .core_sample(core_sample),
		.phase_acc(phase_acc), .scaled_sample(scaled_sample), .scale_factor(scale_factor));
	host_pins_model host_pins_model_i (.clk(clk), .io_update(io_update),
		.keying_input_pin(keying_input_pin));
	// -----------------------------------------------------------------
	// Tasks.
	// -----------------------------------------------------------------
	// Prints the counts and the verdict.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	// Compares one value.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Waits for hready, bounded.
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 100);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			complete_run();
		end
	endtask : wait_ready
	// One single word transfer; read data taken at the closing edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus
	// Reads and compares one register.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask : rd_chk
	// Pulses update and lets the copy land.
	task automatic commit();
		host_pins_model_i.pulse_update();
		repeat (6) @(posedge clk);
	endtask : commit
	// Counts cycles until the factor moves, bounded.
	task automatic wait_change();
		logic [13:0] v;
		v = scale_factor;
		cyc = 0;
		do begin
			@(posedge clk);
			cyc++;
		end while (scale_factor === v && cyc < 200);
		if (cyc == 200) begin
			num_errors++;
			complete_run();
		end
	endtask : wait_change
	// -----------------------------------------------------------------
	// Clock and sequence.
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		// Reset falls just after time zero so every flop sees a clean falling edge.
		reset_n = 1'b1;
		{htrans, hwrite, haddr, hwdata} = '0;
		core_sample = 14'h3000;
		num_errors = 0;
		checks_done = 0;
		#5 reset_n = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 9; n++) begin
			rd_chk(8'(n * 4), 32'h0, "reset read");
		end
		$display("test reset done");
		bus(1'b1, `OFS_TUNING, 32'h100);
		rd_chk(`OFS_TUNING, 32'h0, "tuning before update");
		commit();
		rd_chk(`OFS_TUNING, 32'h100, "tuning after update");
		$display("test buffer done");
		bus(1'b1, `OFS_CONTROL, 32'h400);
		commit();
		for (n = 0; n < 5; n++) begin
			@(posedge clk);
			check("acc held", 32'h0, phase_acc);
		end
		bus(1'b1, `OFS_CONTROL, 32'h0);
		commit();
		a0 = phase_acc;
		@(posedge clk);
		check("acc resumes", a0 + 32'h100, phase_acc);
		$display("test hold done");
		bus(1'b1, `OFS_CONTROL, 32'h2000);
		for (n = 0; n < 2; n++) begin
			repeat (20) @(posedge clk);
			host_pins_model_i.pulse_update();
			repeat (5) @(posedge clk);
			check("acc cleared", 32'h1, 32'(phase_acc < 32'h800));
		end
		bus(1'b1, `OFS_CONTROL, 32'h0);
		commit();
		check("acc not cleared", 32'h1, 32'(phase_acc >= 32'h800));
		$display("test auto clear done");
		check("bypass", 32'h3000, {18'h0, scaled_sample});
		bus(1'b1, `OFS_CONTROL, 32'h0200_0000);
		prev = 14'h0;
		for (n = 0; n < 3; n++) begin
			bus(1'b1, `OFS_AMP_SCALE, {18'h0, FAC[n]});
			check("held factor", {18'h0, prev}, {18'h0, scale_factor});
			commit();
			check("manual factor", {18'h0, FAC[n]}, {18'h0, scale_factor});
			check("scaled out", {18'h0, OUT[n]}, {18'h0, scaled_sample});
			prev = FAC[n];
		end
		$display("test manual done");
		bus(1'b1, `OFS_AMP_SCALE, 32'h8040);
		bus(1'b1, `OFS_RAMP_RATE, 32'h5);
		bus(1'b1, `OFS_CONTROL, 32'h0300_0000);
		host_pins_model_i.set_key(1'b1);
		commit();
		wait_change();
		check("first step", 32'h4, {18'h0, scale_factor});
		wait_change();
		check("step period", 32'h5, 32'(cyc));
		check("second step", 32'h8, {18'h0, scale_factor});
		repeat (100) @(posedge clk);
		check("ceiling", 32'h40, {18'h0, scale_factor});
		host_pins_model_i.set_key(1'b0);
		repeat (150) @(posedge clk);
		check("ramp down", 32'h0, {18'h0, scale_factor});
		$display("test ramp done");
		// Transfers every sync edge keep reloading a slow timer, so no step may come.
		bus(1'b1, `OFS_RAMP_RATE, 32'h28);
		bus(1'b1, `OFS_AMP_SCALE, 32'hc040);
		bus(1'b1, `OFS_CONTROL, 32'h0700_0000);
		host_pins_model_i.set_key(1'b1);
		fork
			host_pins_model_i.hold_update(80);
			begin
				repeat (20) @(posedge clk);
				prev = scale_factor;
				repeat (55) @(posedge clk);
				check("held by reload", {18'h0, prev}, {18'h0, scale_factor});
			end
		join
		wait_change();
		prev = scale_factor;
		wait_change();
		check("rate period", 32'h28, 32'(cyc));
		check("step of eight", {18'h0, prev} + 32'h8, {18'h0, scale_factor});
		$display("test timer load done");
		// The auto bit alone must leave scaling bypassed.
		bus(1'b1, `OFS_CONTROL, 32'h0100_0000);
		commit();
		check("auto ignored", 32'h3000, {18'h0, scaled_sample});
		check("factor shown", 32'h40, {18'h0, scale_factor});
		$display("test disabled auto done");
		complete_run();
	end
endmodule : amplitude_shaping_update_ctrl_tb_top

//--- verif/host_pins_model.sv
/*
 * Host side of the update and keying pins.
 * Assumes its tasks are called just after a rising clock edge.
 */
module host_pins_model (
	// Clock.
	input  wire logic clk,
	// Pins towards the device.
	output logic      io_update,
	output logic      keying_input_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins idle low from time zero.
	initial begin
		io_update = 1'b0;
		keying_input_pin = 1'b0;
	end
	// Holds the pin over four edges so exactly one sync edge sees it.
	task automatic pulse_update();
		io_update <= 1'b1;
		repeat (4) @(posedge clk);
		io_update <= 1'b0;
	endtask : pulse_update
	// Holds the pin high for a number of edges, so every sync edge in between after the first one copies.
	task automatic hold_update(input int edges);
		io_update <= 1'b1;
		repeat (edges) @(posedge clk);
		io_update <= 1'b0;
	endtask : hold_update
	// Sets the ramp direction.
	task automatic set_key(input logic level);
		keying_input_pin <= level;
		@(posedge clk);
	endtask : set_key
endmodule : host_pins_model

//--- verilog/amplitude_shaping_update_ctrl.sv
/*
 * Amplitude shaping, accumulator clearing and double-buffered control
 * registers of a synthesizer core, reached over AHB-Lite.
 * Assumes io_update, keying_input_pin and core_sample are synchronous to
 * clk, and that the one AHB master sees hreadyout as hready.
 */
// The implementer's own choices: register access over AHB-Lite and the register offsets.
// How it works
// - Continuous clear bit holds accumulator at zero.
// - Auto clear zeroes accumulator once per transfer.
// - Auto clear repeats each transfer while set.
// - Enable bit 25 gates scaling, resets cleared.
// - Bit 24 picks auto or manual mode.
// - Auto scale from 14-bit counter, rate paced.
// - Keying pin high ramps up, low down.
// - Scale factor unsigned, zero to full.
// - Top two scale bits pick step 1/2/4/8.
// - Auto ramp capped at scale word ceiling.
// - Ramp timer reloads at count one, cycles.
// - Keying pin change reloads ramp timer.
// - Bit 26 makes transfer reload ramp timer.
// - Entering auto mode reloads ramp timer.
// - Manual mode uses scale word, per transfer.
// - Writes fill buffers; active copies unchanged.
// - Update pulse copies buffers into active registers.
// - Update sampled on sync edge, copied later.
// - Low 14 scale bits: ceiling or factor.
// - Bit 13 auto clear, bit 10 continuous.
// - Sync clock is system clock over four.
`include "osk_defs.svh"

module amplitude_shaping_update_ctrl #(
	parameter int SAMPLE_W = 14,
	parameter int SCALE_W  = 14,
	parameter int RATE_W   = 8
) (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                reset_n,
	// AHB-Lite slave.
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// Host pins.
	input  wire logic                io_update,
	input  wire logic                keying_input_pin,
	// Datapath.
	input  wire logic [SAMPLE_W-1:0] core_sample,
	output logic [31:0]              phase_acc,
	output logic [SAMPLE_W-1:0]      scaled_sample,
	output logic [SCALE_W-1:0]       scale_factor
);
	import osk_pkg::*;

	initial begin
		if (SCALE_W != `SCALE_SHIFT) $error("SCALE_W must equal the scale shift");
		if (RATE_W != 8) $error("RATE_W must be 8 to fit the ramp rate register");
		if (SAMPLE_W < 1 || SAMPLE_W > 32) $error("SAMPLE_W out of range");
	end

	// ----------------------------------------------------------------------
	// Bus slave.
	// ----------------------------------------------------------------------
	ahb_phase_t  dphase;        // Transfer now in its data phase.
	ahb_phase_t  next_dphase;
	logic [31:0] next_hrdata;   // Read data for the coming data phase.
	regs_t       buffered;      // Write buffers filled by software.
	regs_t       next_buffered;
	regs_t       active;        // Active copies that steer the block.
	regs_t       next_active;
	logic        transfer;      // One-cycle buffer-to-active copy.

	// Capture the address phase; read data comes from the active copies, status from the keying pin and the scale factor.
	always_comb begin
		next_dphase       = '0;
		next_hrdata       = 32'h0000_0000;
		if (hsel && hready && htrans[`HTRANS_NONSEQ_BIT]) begin
			next_dphase.valid = 1'b1;
			next_dphase.write = hwrite;
			next_dphase.addr  = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					`OFS_CONTROL:   next_hrdata = active.control;
					`OFS_AMP_SCALE: next_hrdata = {16'h0000, active.amp_scale};
					`OFS_RAMP_RATE: next_hrdata = {24'h00_0000, active.ramp_rate};
					`OFS_TUNING:    next_hrdata = active.tuning;
					`OFS_STATUS:    next_hrdata = {17'h0_0000, keying_input_pin,
						scale_factor};
					default:        next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// Writes land in the buffers only; the active copies wait for a transfer.
	always_comb begin
		next_buffered = buffered;
		if (dphase.valid && dphase.write) begin
			case (dphase.addr)
				`OFS_CONTROL:   next_buffered.control   = hwdata;
				`OFS_AMP_SCALE: next_buffered.amp_scale = hwdata[15:0];
				`OFS_RAMP_RATE: next_buffered.ramp_rate = hwdata[7:0];
				`OFS_TUNING:    next_buffered.tuning    = hwdata;
				default:        next_buffered = buffered;
			endcase
		end
	end

	// Register the bus side; the slave never inserts waits or errors.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dphase    <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			buffered  <= {`RST_CONTROL, `RST_AMP_SCALE, `RST_RAMP_RATE, `RST_TUNING};
		end else begin
			dphase    <= next_dphase;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			buffered  <= next_buffered;
		end
	end

	// ----------------------------------------------------------------------
	// Sync clock and update transfer.
	// ----------------------------------------------------------------------
	logic [1:0] sync_cnt;       // Divider giving the sync clock.
	logic [1:0] next_sync_cnt;
	logic       sync_edge;      // Rising sync clock edge this cycle.
	upd_state_t upd_state;      // Update seen, copy pending.
	upd_state_t next_upd_state;

	assign sync_edge = (sync_cnt == `SYNC_CNT_LAST);

	// Sample the update pin on a sync edge and copy one sync period later.
	always_comb begin
		next_sync_cnt  = sync_cnt + 2'h1;
		next_upd_state = upd_state;
		transfer       = 1'b0;
		case (upd_state)
			UPD_IDLE: begin
				if (sync_edge && io_update) begin
					next_upd_state = UPD_ARMED;
				end
			end
			UPD_ARMED: begin
				if (sync_edge) begin
					transfer       = 1'b1;
					next_upd_state = io_update ? UPD_ARMED : UPD_IDLE;
				end
			end
			default: next_upd_state = UPD_IDLE;
		endcase
	end

	// Active copies change only on a transfer.
	always_comb begin
		next_active = active;
		if (transfer) begin
			next_active = buffered;
		end
	end

	// Register the sync and active state; keying comes up disabled.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_cnt  <= 2'h0;
			upd_state <= UPD_IDLE;
			active    <= {`RST_CONTROL, `RST_AMP_SCALE, `RST_RAMP_RATE, `RST_TUNING};
		end else begin
			sync_cnt  <= next_sync_cnt;
			upd_state <= next_upd_state;
			active    <= next_active;
		end
	end

	// ----------------------------------------------------------------------
	// Phase accumulator.
	// ----------------------------------------------------------------------
	logic [31:0] next_phase_acc;

	// Continuous clear holds zero; auto clear zeroes once per transfer.
	always_comb begin
		if (active.control[`BIT_CONT_CLEAR]) begin
			next_phase_acc = 32'h0000_0000;
		end else if (transfer && buffered.control[`BIT_AUTO_CLEAR]) begin
			next_phase_acc = 32'h0000_0000;
		end else begin
			next_phase_acc = phase_acc + active.tuning;
		end
	end

	// Register the accumulator.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_acc <= 32'h0000_0000;
		end else begin
			phase_acc <= next_phase_acc;
		end
	end

	// ----------------------------------------------------------------------
	// Amplitude ramp.
	// ----------------------------------------------------------------------
	logic               key_enable;   // Scaling is on.
	logic               auto_mode;    // Automatic ramp is active.
	logic               auto_prev;    // Automatic mode one cycle ago.
	logic               key_prev;     // Keying pin one cycle ago.
	logic               timer_load;   // Forced reload of the ramp timer.
	logic               ramp_step;    // Step pulse from the ramp timer.
	logic [SCALE_W-1:0] ramp_count;   // Automatic scale counter.
	logic [SCALE_W-1:0] next_ramp_count;
	logic [SCALE_W-1:0] ceiling;      // Upper bound of the ramp.
	logic [SCALE_W:0]   step_size;    // Amount of one step.
	logic [SCALE_W:0]   sum;          // Counter plus one step.

	assign key_enable = active.control[`BIT_KEY_ENABLE];
	assign auto_mode  = key_enable && active.control[`BIT_KEY_AUTO];
	assign ceiling    = active.amp_scale[`ASW_CEIL_HI:0];
	assign timer_load = (keying_input_pin != key_prev)
		|| (transfer && buffered.control[`BIT_LOAD_TIMER])
		|| (auto_mode && !auto_prev);

	ramp_rate_timer #(
		.RATE_W (RATE_W)
	) ramp_rate_timer_i (
		.clk     (clk),
		.reset_n (reset_n),
		.enable  (auto_mode),
		.load    (timer_load),
		.rate    (active.ramp_rate),
		.step    (ramp_step)
	);

	// Step up toward the ceiling while the pin is high, down toward zero when low.
	always_comb begin
		case (active.amp_scale[`ASW_STEP_HI:`ASW_STEP_LO])
			2'h0:    step_size = (SCALE_W+1)'(1);
			2'h1:    step_size = (SCALE_W+1)'(2);
			2'h2:    step_size = (SCALE_W+1)'(4);
			default: step_size = (SCALE_W+1)'(8);
		endcase
		sum             = {1'b0, ramp_count} + step_size;
		next_ramp_count = ramp_count;
		if (auto_mode && ramp_step) begin
			if (keying_input_pin) begin
				if (sum > {1'b0, ceiling}) begin
					next_ramp_count = ceiling;
				end else begin
					next_ramp_count = sum[SCALE_W-1:0];
				end
			end else if ({1'b0, ramp_count} < step_size) begin
				next_ramp_count = '0;
			end else begin
				next_ramp_count = ramp_count - step_size[SCALE_W-1:0];
			end
		end
	end

	// Register the ramp state.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ramp_count <= '0;
			auto_prev  <= 1'b0;
			key_prev   <= 1'b0;
		end else begin
			ramp_count <= next_ramp_count;
			auto_prev  <= auto_mode;
			key_prev   <= keying_input_pin;
		end
	end

	// ----------------------------------------------------------------------
	// Output scaling.
	// ----------------------------------------------------------------------
	logic [SCALE_W-1:0]          next_scale_factor;
	logic [SAMPLE_W-1:0]         next_scaled_sample;
	logic [SAMPLE_W+SCALE_W-1:0] product;   // Unsigned sample times scale.

	// Choose the factor, then multiply and drop the low scale bits.
	always_comb begin
		if (auto_mode) begin
			next_scale_factor = ramp_count;
		end else begin
			next_scale_factor = active.amp_scale[`ASW_CEIL_HI:0];
		end
		product = core_sample * next_scale_factor;
		if (key_enable) begin
			next_scaled_sample = product[SAMPLE_W+SCALE_W-1:`SCALE_SHIFT];
		end else begin
			next_scaled_sample = core_sample;
		end
	end

	// Register the datapath outputs.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scale_factor  <= '0;
			scaled_sample <= '0;
		end else begin
			scale_factor  <= next_scale_factor;
			scaled_sample <= next_scaled_sample;
		end
	end

	// Size and mode lines of the bus are accepted as the word-only master drives them.
	logic unused_ok;
	assign unused_ok = ^{haddr[31:8], hsize, htrans[0]};

endmodule : amplitude_shaping_update_ctrl

//--- verilog/ramp_rate_timer.sv
/*
 * Loadable down counter that paces the scale factor ramp.
 * Assumes a single clock and an asynchronous active-low reset.
 */
module ramp_rate_timer #(
	parameter int RATE_W = 8
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Control.
	input  wire logic              enable,
	input  wire logic              load,
	input  wire logic [RATE_W-1:0] rate,
	// Step pulse to the scale counter.
	output logic                   step
);

	initial begin
		if (RATE_W < 2) $error("ramp_rate_timer: RATE_W must be at least 2");
	end

	logic [RATE_W-1:0] count;       // Current count.
	logic [RATE_W-1:0] next_count;  // Next count.

	// A forced load wins; otherwise reload on reaching one and emit a step.
	always_comb begin
		next_count = count;
		step       = 1'b0;
		if (!enable || load) begin
			next_count = rate;
		end else if (count <= RATE_W'(1)) begin
			next_count = rate;
			step       = 1'b1;
		end else begin
			next_count = count - RATE_W'(1);
		end
	end

	// Register the count.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule : ramp_rate_timer
